// file: rtl/wake_meas_pkg.sv
// Constants and types shared by the wake input measurement control logic
package wake_meas_pkg;

    // Operating modes, one-hot
    typedef enum logic [5:0] {
        MODE_INIT     = 6'b00_0001,
        MODE_NORMAL   = 6'b00_0010,
        MODE_STOP     = 6'b00_0100,
        MODE_SLEEP    = 6'b00_1000,
        MODE_RESTART  = 6'b01_0000,
        MODE_FAILSAFE = 6'b10_0000
    } sbc_mode_e;

    // Clock rate and filter times
    localparam int CLK_MHZ            = 100;
    localparam int SHORT_FILTER_US    = 16;
    localparam int LONG_FILTER_US     = 64;
    localparam int SHORT_FILTER_CYC   = SHORT_FILTER_US * CLK_MHZ;
    localparam int LONG_FILTER_CYC    = LONG_FILTER_US * CLK_MHZ;

    // Pull configuration field codes
    localparam logic [1:0] PULL_NONE  = 2'h0;
    localparam logic [1:0] PULL_DOWN  = 2'h1;
    localparam logic [1:0] PULL_UP    = 2'h2;
    localparam logic [1:0] PULL_AUTO  = 2'h3;

    // Filter configuration: code 1 is static long filter, others short
    localparam logic [1:0] FILT_LONG  = 2'h1;

    // Pin indices
    localparam int SENSE_IDX          = 0;
    localparam int OUT_IDX            = 1;

endpackage

// file: rtl/wake_filter.sv
// Edge filter for one wake input
`timescale 1ns/100ps
module wake_filter
    import wake_meas_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_FILTER_CYC,
    parameter int LONG_CYC  = LONG_FILTER_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pinLevel,     // Comparator output, already gated
    input  wire logic gate,         // Freeze filter while gated
    input  wire logic longSel,      // Long filter selected
    output logic      stableLevel,  // Filtered level
    output logic      edgePulse     // One cycle on accepted transition
);

    localparam int CW = $clog2(LONG_CYC + 1);

    logic [CW-1:0] cnt_r;           // Cycles the new level has held
    logic          stable_r;        // Accepted level
    logic [CW-1:0] limit;           // Selected filter length

    // Filter length follows selection
    assign limit = longSel ? CW'(LONG_CYC) : CW'(SHORT_CYC);

    // Count while input differs; crossing back resets the count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r    <= '0;
            stable_r <= 1'b0;
            edgePulse <= 1'b0;
        end else begin
            edgePulse <= 1'b0;
            if (gate || pinLevel == stable_r) begin
                cnt_r <= '0;
            end else if (cnt_r + CW'(1) >= limit) begin
                // Either direction is an event
                cnt_r     <= '0;
                stable_r  <= pinLevel;
                edgePulse <= 1'b1;
            end else begin
                cnt_r <= cnt_r + CW'(1);
            end
        end
    end

    assign stableLevel = stable_r;

endmodule

// file: rtl/wake_input_voltage_measure_ctrl.sv
// Measurement mode control and gating for the two shared wake inputs
`timescale 1ns/100ps
module wake_input_voltage_measure_ctrl
    import wake_meas_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_FILTER_CYC,
    parameter int LONG_CYC  = LONG_FILTER_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [5:0] sbcMode,            // Current mode, one-hot
    input  wire logic       measEnWrite,        // Write strobe for enable bit
    input  wire logic       measEnData,         // Value written
    input  wire logic       cfgWrite,           // Write strobe for pin config
    input  wire logic [3:0] pullCfgData,        // Pull codes, 2 bits per pin
    input  wire logic [3:0] filtCfgData,        // Filter codes, 2 bits per pin
    input  wire logic [1:0] wakeEnData,         // Wake enables per pin
    input  wire logic       otherWakeSrc,       // Any other wake source enabled
    input  wire logic       sleepCmd,           // Sleep command pulse
    input  wire logic [1:0] pinComp,            // Comparator levels, pins 0/1
    input  wire logic       statusClear,        // Clear wake status pulse
    output logic            measurement_enable, // Stored enable bit
    output logic            measure_switch,     // Switch closed when high
    output logic [1:0]      pullUpOn,           // Pull-up source per pin
    output logic [1:0]      pullDownOn,         // Pull-down source per pin
    output logic [3:0]      pull_config_reg,    // Stored pull config
    output logic [3:0]      filter_config_reg,  // Stored filter config
    output logic [1:0]      wake_enable_reg,    // Stored wake enables
    output logic [1:0]      wake_status_reg,    // Sticky wake flags
    output logic [1:0]      aux_wake_status_reg,// Sticky event flags
    output logic [1:0]      pin_level_status_reg,// Filtered pin levels
    output logic            wakeEvent,          // Wake request pulse
    output logic            intEvent,           // Interrupt request pulse
    output logic            cmdFault,           // Command fault flag
    output logic            restartReq          // Restart mode request pulse
);

    // Pin count and per-pin config field width
    localparam int NPIN = OUT_IDX + 1;  // Sense pin and output pin
    localparam int FW   = 2;            // Config bits per pin

    // Internal state
    logic       meas_r;                 // Enable bit
    logic       sw_r;                   // Switch control
    logic [3:0] pull_r;                 // Stored pull config
    logic [3:0] filt_r;                 // Stored filter config
    logic [1:0] wen_r;                  // Stored wake enables
    logic [1:0] wstat_r;                // Wake status
    logic [1:0] aux_r;                  // Auxiliary status
    logic [1:0] lvl_r;                  // Level status
    logic       fault_r;                // Command fault
    logic       restart_r;              // Restart request
    logic       wake_r;                 // Wake pulse
    logic       int_r;                  // Interrupt pulse
    logic       isNormal;               // Mode is normal
    logic       evtMode;                // Mode signals by interrupt
    logic       wakeMode;               // Mode signals by wake-up
    logic [1:0] gatedComp;              // Comparator after gating
    logic [1:0] stable;                 // Filter outputs
    logic [1:0] edgeP;                  // Filter edge pulses
    logic [1:0] pinEvt;                 // Accepted and enabled events
    logic       onlyGated;              // Only shared pins can wake

    // Mode decodes from the one-hot mode input; interrupts serve the
    // awake modes and wake-ups the low-power ones, the rest stay
    // silent
    assign isNormal = (sbcMode == MODE_NORMAL);
    assign evtMode  = (sbcMode == MODE_NORMAL) || (sbcMode == MODE_STOP);
    assign wakeMode = (sbcMode == MODE_SLEEP) || (sbcMode == MODE_FAILSAFE);

    // Enable bit, cleared by reset
    // Written as a whole; nothing else touches it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meas_r <= 1'b0;
        end else if (measEnWrite) begin
            meas_r <= measEnData;
        end
    end

    // Switch re-evaluated every cycle from bit and mode
    // Registered so the switch driver never sees a decode glitch;
    // leaving normal mode opens it one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_r <= 1'b0;
        end else begin
            sw_r <= meas_r && isNormal;
        end
    end

    // Config always stored, even when enabled
    // Stored values read back unchanged, so software may prepare
    // them before turning the function off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pull_r <= 4'h0;
            filt_r <= 4'h0;
            wen_r  <= 2'h0;
        end else if (cfgWrite) begin
            pull_r <= pullCfgData;
            filt_r <= filtCfgData;
            wen_r  <= wakeEnData;
        end
    end

    // Comparator gated while measurement enabled
    // Forcing the comparators low keeps the loaded pins from
    // starting the filters while the switch is in use
    assign gatedComp = meas_r ? 2'h0 : pinComp;

    // One filter per pin; config ignored while gated
    // The filter holds its counter cleared while gated, so a stale
    // partial count cannot complete once the gate opens
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : gFilt
            wake_filter #(
                .SHORT_CYC (SHORT_CYC),
                .LONG_CYC  (LONG_CYC)
            ) uFilt (
                .clk         (clk),
                .rst_n       (rst_n),
                .pinLevel    (gatedComp[g]),
                .gate        (meas_r),
                .longSel     (filt_r[FW*g +: FW] == FILT_LONG),
                .stableLevel (stable[g]),
                .edgePulse   (edgeP[g])
            );
            // Pull sources off while enabled, else per config
            // Automatic switching follows the filtered level, so the
            // source flips only once the filter accepts a new level
            always_comb begin
                pullUpOn[g]   = 1'b0;
                pullDownOn[g] = 1'b0;
                if (!meas_r) begin
                    case (pull_r[FW*g +: FW])
                        PULL_DOWN: pullDownOn[g] = 1'b1;
                        PULL_UP:   pullUpOn[g]   = 1'b1;
                        PULL_AUTO: begin
                            pullUpOn[g]   = stable[g];
                            pullDownOn[g] = !stable[g];
                        end
                        default:   ;
                    endcase
                end
            end
        end
    endgenerate

    // Events only when enabled as wake source and not gated
    // Pins that are not wake sources still report their level
    assign pinEvt = meas_r ? 2'h0 : (edgeP & wen_r);

    // Wake and auxiliary status never set while enabled, only cleared; set beats clear
    // A clear in the event's cycle keeps the event, so no wake is
    // lost to a read-and-clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wstat_r <= 2'h0;
            aux_r   <= 2'h0;
        end else begin
            wstat_r <= (statusClear ? 2'h0 : wstat_r) | pinEvt;
            aux_r   <= (statusClear ? 2'h0 : aux_r) | pinEvt;
        end
    end

    // Level status held while enabled
    // Levels are updated only in normal and stop modes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_r <= 2'h0;
        end else if (!meas_r && evtMode) begin
            lvl_r <= stable;
        end
    end

    // Event signalling: interrupt or wake-up by mode
    // Registered pulses, one cycle long
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_r  <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            int_r  <= (|pinEvt) && evtMode;
            wake_r <= (|pinEvt) && wakeMode;
        end
    end

    // Sleep refused when only gated pins could wake
    // Any other enabled source lets the sleep go ahead
    assign onlyGated = meas_r && (|wen_r) && !otherWakeSrc;

    // Fault is sticky until cleared; a refused sleep and a clear in
    // one cycle keep the fault
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_r   <= 1'b0;
            restart_r <= 1'b0;
        end else begin
            restart_r <= sleepCmd && onlyGated;
            if (sleepCmd && onlyGated) begin
                fault_r <= 1'b1;
            end else if (statusClear) begin
                fault_r <= 1'b0;
            end
        end
    end

    // Register outputs
    assign measurement_enable   = meas_r;
    assign measure_switch       = sw_r;
    assign pull_config_reg      = pull_r;
    assign filter_config_reg    = filt_r;
    assign wake_enable_reg      = wen_r;
    assign wake_status_reg      = wstat_r;
    assign aux_wake_status_reg  = aux_r;
    assign pin_level_status_reg = lvl_r;
    assign wakeEvent            = wake_r;
    assign intEvent             = int_r;
    assign cmdFault             = fault_r;
    assign restartReq           = restart_r;

endmodule

// file: testbench/wake_meas_sva.sv
// Port assertions for the measurement control block
`timescale 1ns/100ps
module wake_meas_sva
    import wake_meas_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_FILTER_CYC,
    parameter int LONG_CYC  = LONG_FILTER_CYC
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       measEnWrite,
    input wire logic       measEnData,
    input wire logic       cfgWrite,
    input wire logic       sleepCmd,
    input wire logic       otherWakeSrc,
    input wire logic       statusClear,
    input wire logic       measurement_enable,
    input wire logic       measure_switch,
    input wire logic       wakeEvent,
    input wire logic       intEvent,
    input wire logic       cmdFault,
    input wire logic       restartReq,
    input wire logic [5:0] sbcMode,
    input wire logic [3:0] pullCfgData,
    input wire logic [3:0] pull_config_reg,
    input wire logic [1:0] wakeEnData,
    input wire logic [1:0] pullUpOn,
    input wire logic [1:0] pullDownOn,
    input wire logic [1:0] wake_enable_reg,
    input wire logic [1:0] wake_status_reg,
    input wire logic [1:0] aux_wake_status_reg,
    input wire logic [1:0] pin_level_status_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Enable held two cycles, so the gating has taken hold
    sequence s_held;
        measurement_enable [*2];
    endsequence
    // One-cycle restart request with the fault flag raised
    sequence s_fault;
        restartReq && cmdFault ##1 !restartReq;
    endsequence
    property p_enStore;
        measEnWrite |=> measurement_enable == $past(measEnData);
    endproperty
    a_enStore: assert property (p_enStore) else $error("enable bit not stored");
    property p_close;
        measurement_enable && sbcMode == MODE_NORMAL |=> measure_switch;
    endproperty
    a_close: assert property (p_close) else $error("switch not closed");
    property p_open;
        sbcMode != MODE_NORMAL || !measurement_enable |=> !measure_switch;
    endproperty
    a_open: assert property (p_open) else $error("switch not open");
    property p_pulls;
        measurement_enable |-> pullUpOn == 2'h0 && pullDownOn == 2'h0;
    endproperty
    a_pulls: assert property (p_pulls) else $error("pull source on");
    property p_cfg;
        cfgWrite |=> pull_config_reg == $past(pullCfgData) && wake_enable_reg == $past(wakeEnData);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config not stored");
    property p_frozen;
        s_held ##0 !statusClear |=> $stable(wake_status_reg) && $stable(pin_level_status_reg);
    endproperty
    a_frozen: assert property (p_frozen) else $error("status moved");
    property p_aux;
        s_held ##0 !statusClear |=> $stable(aux_wake_status_reg);
    endproperty
    a_aux: assert property (p_aux) else $error("aux status moved");
    property p_quiet;
        s_held |-> !wakeEvent && !intEvent;
    endproperty
    a_quiet: assert property (p_quiet) else $error("event while gated");
    property p_fault;
        sleepCmd && measurement_enable && wake_enable_reg != 2'h0 && !otherWakeSrc |=> s_fault;
    endproperty
    a_fault: assert property (p_fault) else $error("no fault on sleep");
endmodule

// file: testbench/mcu_model.sv
// Microcontroller model: enable writes and sleep commands
`timescale 1ns/100ps
module mcu_model (
    input  wire logic clk,
    output logic      measEnWrite,
    output logic      measEnData,
    output logic      sleepCmd
);
    initial begin
        measEnWrite = 0;
        measEnData = 0;
        sleepCmd = 0;
    end
    // One-cycle write strobe; data shows the inverse once released
    task automatic writeEn(input logic v);
        measEnWrite = 1;
        measEnData = v;
        @(posedge clk);
        #1;
        measEnWrite = 0;
        measEnData = ~v;
    endtask
    // Sleep command, also sent when only shared pins wake
    task automatic sendSleep();
        sleepCmd = 1;
        @(posedge clk);
        #1;
        sleepCmd = 0;
    endtask
endmodule

// file: testbench/wake_input_voltage_measure_ctrl_tb.sv
// Self-checking bench for the measurement control block
`timescale 1ns/100ps
module wake_input_voltage_measure_ctrl_tb;
    import wake_meas_pkg::*;
    localparam int SC = 4;   // Shortened filter counts
    localparam int LC = 16;
    logic       clk = 0, rst_n = 0, cfgWrite = 0, otherWakeSrc = 0, statusClear = 0;
    logic [5:0] sbcMode = MODE_NORMAL;
    logic [3:0] pullCfgData = 0, filtCfgData = 0, pcr, fcr;
    logic [1:0] wakeEnData = 0, pinComp = 0, pullUpOn, pullDownOn, wen, wst, ast, lst;
    logic       measEnWrite, measEnData, sleepCmd, en, sw, wk, irq, flt, rq;
    logic [1:0] pe;          // Expected {pull-up, pull-down} of the sense pin
    int         n_errors = 0, compares = 0, cnt, n;
    int         seed = 32'h7842_bdeb;
    logic [3:0] expQ[$];     // Expected {wake, int, restart, fault}
    always #5 clk = ~clk;
    mcu_model mcu_model_inst (.clk(clk), .measEnWrite(measEnWrite),
        .measEnData(measEnData), .sleepCmd(sleepCmd));
    wake_input_voltage_measure_ctrl #(.SHORT_CYC(SC), .LONG_CYC(LC))
    wake_input_voltage_measure_ctrl_inst (.clk(clk), .rst_n(rst_n), .sbcMode(sbcMode),
        .measEnWrite(measEnWrite), .measEnData(measEnData), .cfgWrite(cfgWrite),
        .pullCfgData(pullCfgData), .filtCfgData(filtCfgData), .wakeEnData(wakeEnData),
        .otherWakeSrc(otherWakeSrc), .sleepCmd(sleepCmd), .pinComp(pinComp),
        .statusClear(statusClear), .measurement_enable(en), .measure_switch(sw),
        .pullUpOn(pullUpOn), .pullDownOn(pullDownOn), .pull_config_reg(pcr),
        .filter_config_reg(fcr), .wake_enable_reg(wen), .wake_status_reg(wst),
        .aux_wake_status_reg(ast), .pin_level_status_reg(lst), .wakeEvent(wk),
        .intEvent(irq), .cmdFault(flt), .restartReq(rq));
    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic setCfg(input logic [3:0] p, input logic [3:0] f, input logic [1:0] w);
        cfgWrite = 1;
        pullCfgData = p;
        filtCfgData = f;
        wakeEnData = w;
        tick(1);
        cfgWrite = 0;
    endtask
    task automatic clearStat();
        statusClear = 1;
        tick(1);
        statusClear = 0;
        tick(1);
    endtask
    task automatic end_of_test();
        $display("compares %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Any event takes the oldest expectation; none queued means unexpected
    // Sampled mid-cycle, where the one-cycle pulses have settled
    always @(negedge clk) begin
        if (wk | irq | rq) begin
            if (expQ.size() == 0) chk({wk, irq, rq, flt}, 4'h0);
            else chk({wk, irq, rq, flt}, expQ.pop_front());
        end
    end
    initial begin
        #100_000;
        n_errors++;
        end_of_test();
    end
    initial begin
        tick(3);
        rst_n = 1;
        chk({en, sw, wst, lst}, 6'h0);
        $display("test reset done");
        mcu_model_inst.writeEn(1);
        setCfg(4'ha, 4'h5, 2'h3);
        chk({pcr, fcr, wen}, 10'h297);
        chk({pullUpOn, pullDownOn}, 4'h0);
        for (int m = 0; m < 6; m++) begin
            sbcMode = 6'(1 << m);
            tick(2);
            chk(sw, m == 1);
        end
        sbcMode = MODE_NORMAL;
        repeat (40) begin
            pinComp = 2'($random(seed));
            tick(1 + {$random(seed)} % 6);
        end
        pinComp = 2'h0;
        tick(2);
        chk({wst, ast, lst}, 6'h0);
        $display("test gating done");
        otherWakeSrc = 1;
        mcu_model_inst.sendSleep();
        tick(3);
        otherWakeSrc = 0;
        expQ.push_back(4'h3);
        mcu_model_inst.sendSleep();
        tick(3);
        chk(flt, 1);
        clearStat();
        chk(flt, 0);
        $display("test sleep fault done");
        mcu_model_inst.writeEn(0);
        sbcMode = MODE_STOP;
        for (int c = 0; c < 4; c++) begin
            setCfg(4'(c * 5), 4'(c * 5), 2'h1);
            n = (c == FILT_LONG) ? LC : SC;
            pe = {c == 2 || (c == 3 && pinComp[0]), c == 1 || (c == 3 && !pinComp[0])};
            chk({pullUpOn[0], pullDownOn[0]}, pe);
            pinComp[0] = ~pinComp[0];
            tick(n - 2);
            pinComp[0] = ~pinComp[0];
            tick(n + 4);
            expQ.push_back(4'h4);
            pinComp[0] = ~pinComp[0];
            cnt = 0;
            while (irq !== 1'b1 && cnt < 100) begin
                tick(1);
                cnt++;
            end
            chk(cnt >= n && cnt <= n + 2, 1);
            tick(2);
            chk(lst[0], pinComp[0]);
        end
        chk(ast[0], 1);
        clearStat();
        setCfg(4'h0, 4'h0, 2'h2);
        sbcMode = MODE_SLEEP;
        expQ.push_back(4'h8);
        pinComp[1] = ~pinComp[1];
        tick(SC + 4);
        chk(wst, 2'h2);
        chk(ast, 2'h2);
        chk(expQ.size(), 0);
        $display("test filter and wake done");
        end_of_test();
    end
endmodule
bind wake_input_voltage_measure_ctrl wake_meas_sva #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC))
wake_meas_sva_inst (.clk(clk), .rst_n(rst_n), .measEnWrite(measEnWrite),
    .measEnData(measEnData), .cfgWrite(cfgWrite), .sleepCmd(sleepCmd),
    .otherWakeSrc(otherWakeSrc), .statusClear(statusClear),
    .measurement_enable(measurement_enable), .measure_switch(measure_switch),
    .wakeEvent(wakeEvent), .intEvent(intEvent), .cmdFault(cmdFault),
    .restartReq(restartReq), .sbcMode(sbcMode), .pullCfgData(pullCfgData),
    .pull_config_reg(pull_config_reg), .wakeEnData(wakeEnData), .pullUpOn(pullUpOn),
    .pullDownOn(pullDownOn), .wake_enable_reg(wake_enable_reg),
    .wake_status_reg(wake_status_reg), .aux_wake_status_reg(aux_wake_status_reg),
    .pin_level_status_reg(pin_level_status_reg));
